/* hdl/lsd_pkg.sv */
// Package for the segment display controller: map, fields, types
package lsd_pkg;
    // ----------------------------------------
    // Register map, word addresses
    // ----------------------------------------
    localparam int          ADDR_W     = 4;
    localparam logic [3:0]  A_CTRL     = 4'h0;
    localparam logic [3:0]  A_DIV      = 4'h1;
    localparam logic [3:0]  A_DISCH    = 4'h2;
    localparam logic [3:0]  A_CONTRAST = 4'h3;
    localparam logic [3:0]  A_BLINK    = 4'h4;
    localparam logic [3:0]  A_STATUS   = 4'h5;
    localparam logic [3:0]  A_CLEAR    = 4'h6;
    localparam logic [3:0]  A_INTEN    = 4'h7;
    localparam int          SEG_SEL    = 3;   // Address bit picking seg words
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int          C_EN       = 0;
    localparam int          C_MUX      = 1;   // Two bits
    localparam int          C_THIRD    = 3;
    localparam int          C_ACM      = 4;   // Two bits
    localparam int          C_WKEN     = 6;
    localparam int          B_RATE     = 8;   // Eight bits
    localparam int          S_RO       = 8;   // Live state in status
    localparam int          N_SEG      = 40;
    localparam int          N_COM      = 4;
    localparam int          N_BLINK    = 8;
    localparam int          N_EV       = 4;
    localparam int          EV_FRAME   = 0;
    localparam int          EV_VBAT    = 1;
    localparam int          EV_BLINK   = 2;
    localparam int          EV_DISCH   = 3;
    localparam logic [15:0] DIV_RST    = 16'h0001;
    localparam logic [7:0]  BRATE_RST  = 8'h10;
    localparam logic [5:0]  CON_RST    = 6'h20;
    // ----------------------------------------
    // Drive level codes, V0 lowest
    // ----------------------------------------
    localparam logic [1:0]  LV0        = 2'h0;
    localparam logic [1:0]  LV1        = 2'h1;
    localparam logic [1:0]  LV2        = 2'h2;
    localparam logic [1:0]  LV3        = 2'h3;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        SQ_IDLE  = 3'h1,
        SQ_DRIVE = 3'h2,
        SQ_DISCH = 3'h4
    } lsd_seq_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } lsd_bus_t;

    typedef struct packed {
        logic [2:0]                      rtc_s;
        logic [2:0]                      vb_s;
        logic [1:0]                      sl_s;
        logic                            en;
        logic [1:0]                      mux;
        logic                            third;
        logic [1:0]                      acm;
        logic                            wken;
        logic [15:0]                     div;
        logic [7:0]                      dis;
        logic [5:0]                      con;
        logic [N_BLINK-1:0]              bmask;
        logic [7:0]                      brate;
        logic [N_COM-1:0][N_SEG-1:0]     seg;
        logic [N_EV-1:0]                 sts;
        logic [N_EV-1:0]                 ien;
        lsd_seq_t                        seq;
        logic [15:0]                     cnt;
        logic [1:0]                      slot;
        logic                            ph;
        logic [7:0]                      bcnt;
        logic                            bon;
        logic [2*N_SEG-1:0]              seg_lvl;
        logic [2*N_COM-1:0]              com_lvl;
        logic                            disch;
        logic                            wake;
        logic                            irq;
        logic [31:0]                     rdata;
    } lsd_state_t;
endpackage : lsd_pkg

/* hdl/lsd_top.sv */
// Segment display controller: registers, sequencer, waveform levels
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
// Operation
// R1 - Static, 2-, 3- or 4-mux drive chosen by control mux field.
// R2 - Half or one-third bias level sequences chosen by control bit.
// R3 - Forty segment outputs and four common outputs, each own waveform.
// R4 - All frame timing counts edges of the low frequency timer clock.
// R5 - One state bit per segment in registers drives every waveform.
// R6 - Optional discharge interval of programmed timer clock cycles.
// R7 - Hardware blinking of up to eight segments without rewriting bits.
// R8 - Four auto-contrast modes selected by a mode field.
// R9 - Battery monitor trip can be enabled as deepest sleep wakeup.
// R10 - Programmable contrast setting drives charge pump level.
// R11 - Controller keeps running in deepest sleep mode.
// R12 - Commons active in turn per slot; unused commons held inactive.
module lsd_top (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire lsd_pkg::lsd_bus_t             bus,
    input  wire logic                          low_freq_timer_clock,
    input  wire logic                          vbat_low,
    input  wire logic                          deepest_sleep_mode,
    output logic [31:0]                        rdata,
    output logic [2*lsd_pkg::N_SEG-1:0]        seg_level,
    output logic [2*lsd_pkg::N_COM-1:0]        common_drive_outputs,
    output logic                               discharge,
    output logic [5:0]                         contrast,
    output logic [1:0]                         contrast_mode,
    output logic                               wake,
    output logic                               irq
);
    lsd_pkg::lsd_state_t s;
    lsd_pkg::lsd_state_t n;

    // ----------------------------------------
    // Level selection
    // ----------------------------------------
    // Seg on is the inverse of a selected common, so the cell sees full
    // swing; the two phases of a slot keep the cell free of DC.
    function automatic logic [1:0] lvl(
        input logic is_com,
        input logic act,
        input logic ph,
        input logic third,
        input logic stat
    );
        logic [1:0] vmax;
        vmax = (third && !stat) ? lsd_pkg::LV3 : lsd_pkg::LV2;   // [R2]
        if (is_com) begin
            if (act)
                lvl = ph ? lsd_pkg::LV0 : vmax;
            else if (third)
                lvl = ph ? lsd_pkg::LV2 : lsd_pkg::LV1;
            else
                lvl = lsd_pkg::LV1;
        end else begin
            if (act)
                lvl = ph ? vmax : lsd_pkg::LV0;
            else if (third && !stat)
                lvl = ph ? lsd_pkg::LV1 : lsd_pkg::LV2;
            else
                lvl = ph ? lsd_pkg::LV0 : vmax;
        end
    endfunction : lvl

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Address bit three splits segment words from control registers
    function automatic logic seg_word(
        input logic [lsd_pkg::ADDR_W-1:0] a
    );
        seg_word = a[lsd_pkg::SEG_SEL];
    endfunction : seg_word

    // Two words per common: low pins, then pins 39:32
    function automatic logic [1:0] seg_com(
        input logic [lsd_pkg::ADDR_W-1:0] a
    );
        seg_com = a[2:1];
    endfunction : seg_com

    // Wraps silently; callers compare against the limit first
    function automatic logic [15:0] step16(
        input logic [15:0] v
    );
        step16 = v + 16'h0001;
    endfunction : step16

    function automatic logic running(
        input lsd_pkg::lsd_seq_t q
    );
        running = (q == lsd_pkg::SQ_DRIVE);
    endfunction : running

    function automatic logic [31:0] ctrl_word(
        input lsd_pkg::lsd_state_t q
    );
        ctrl_word = {25'h0, q.wken, q.acm, q.third, q.mux, q.en};
    endfunction : ctrl_word

    // Live state above the sticky bits; bits 7:4 read as zero
    function automatic logic [31:0] status_word(
        input lsd_pkg::lsd_state_t q
    );
        status_word = {17'h0, q.bon, q.ph, q.slot, q.disch,
                       running(q.seq), q.sl_s[1], 4'h0, q.sts};
    endfunction : status_word

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic                         tick;
        logic                         adv;
        logic                         on;
        logic                         run;
        logic [lsd_pkg::N_EV-1:0]     ev;
        logic [1:0]                   wc;
        tick = 1'b0;
        adv  = 1'b0;
        on   = 1'b0;
        run  = 1'b0;
        ev   = '0;
        wc   = seg_com(bus.addr);
        n    = s;
        // Sampling the timer clock costs resolution but keeps one domain
        n.rtc_s = {s.rtc_s[1:0], low_freq_timer_clock};
        n.vb_s  = {s.vb_s[1:0], vbat_low};
        n.sl_s  = {s.sl_s[0], deepest_sleep_mode};
        tick    = s.rtc_s[1] & ~s.rtc_s[2];                      // [R4]
        ev[lsd_pkg::EV_VBAT] = s.vb_s[1] & ~s.vb_s[2];           // [R9]

        if (bus.wr) begin
            if (seg_word(bus.addr)) begin
                if (bus.addr[0])
                    n.seg[wc][39:32] = bus.wdata[7:0];           // [R5]
                else
                    n.seg[wc][31:0] = bus.wdata;                 // [R5]
            end else begin
                case (bus.addr)
                    lsd_pkg::A_CTRL: begin
                        n.en    = bus.wdata[lsd_pkg::C_EN];
                        n.mux   = bus.wdata[lsd_pkg::C_MUX +: 2]; // [R1]
                        n.third = bus.wdata[lsd_pkg::C_THIRD];   // [R2]
                        n.acm   = bus.wdata[lsd_pkg::C_ACM +: 2]; // [R8]
                        n.wken  = bus.wdata[lsd_pkg::C_WKEN];    // [R9]
                    end
                    lsd_pkg::A_DIV:      n.div = bus.wdata[15:0];
                    lsd_pkg::A_DISCH:    n.dis = bus.wdata[7:0]; // [R6]
                    lsd_pkg::A_CONTRAST: n.con = bus.wdata[5:0]; // [R10]
                    lsd_pkg::A_BLINK: begin
                        n.bmask = bus.wdata[lsd_pkg::N_BLINK-1:0]; // [R7]
                        n.brate = bus.wdata[lsd_pkg::B_RATE +: 8];
                    end
                    lsd_pkg::A_CLEAR:
                        n.sts = s.sts & ~bus.wdata[lsd_pkg::N_EV-1:0];
                    lsd_pkg::A_INTEN:
                        n.ien = bus.wdata[lsd_pkg::N_EV-1:0];
                    default: ;
                endcase
            end
        end

        // Sleep input is only reported; nothing here stops in sleep  [R11]
        case (s.seq)
            lsd_pkg::SQ_IDLE: begin
                n.cnt  = '0;
                n.slot = '0;
                n.ph   = 1'b0;
                if (s.en)
                    n.seq = lsd_pkg::SQ_DRIVE;
            end
            lsd_pkg::SQ_DRIVE: begin
                if (!s.en)
                    n.seq = lsd_pkg::SQ_IDLE;
                else if (tick) begin
                    if (s.cnt >= s.div) begin                    // [R4]
                        n.cnt = '0;
                        if (s.dis != 8'h00) begin
                            n.seq = lsd_pkg::SQ_DISCH;           // [R6]
                            ev[lsd_pkg::EV_DISCH] = 1'b1;
                        end else
                            adv = 1'b1;
                    end else
                        n.cnt = step16(s.cnt);
                end
            end
            lsd_pkg::SQ_DISCH: begin
                if (!s.en)
                    n.seq = lsd_pkg::SQ_IDLE;
                else if (tick) begin
                    if (step16(s.cnt) >= {8'h00, s.dis}) begin   // [R6]
                        n.cnt = '0;
                        n.seq = lsd_pkg::SQ_DRIVE;
                        adv   = 1'b1;
                    end else
                        n.cnt = step16(s.cnt);
                end
            end
            default: n.seq = lsd_pkg::SQ_IDLE;
        endcase

        if (adv) begin
            n.ph = ~s.ph;
            if (s.ph) begin
                if (s.slot >= s.mux) begin                       // [R12]
                    n.slot = '0;
                    ev[lsd_pkg::EV_FRAME] = 1'b1;
                    if (s.bcnt >= s.brate) begin                 // [R7]
                        n.bcnt = '0;
                        n.bon  = ~s.bon;
                        ev[lsd_pkg::EV_BLINK] = 1'b1;
                    end else
                        n.bcnt = s.bcnt + 8'h01;
                end else
                    n.slot = s.slot + 2'h1;
            end
        end

        // Event set wins over a clear in the same cycle
        n.sts  = n.sts | ev;
        n.irq  = |(n.sts & n.ien);
        n.wake = n.wken & s.vb_s[1];                             // [R9]

        // ----------------------------------------
        // Pin levels
        // ----------------------------------------
        run       = running(n.seq);
        n.disch   = (n.seq == lsd_pkg::SQ_DISCH);                // [R6]
        n.com_lvl = '0;
        n.seg_lvl = '0;
        for (int k = 0; k < lsd_pkg::N_COM; k++) begin
            if (run && k <= n.mux)                               // [R12]
                n.com_lvl[2*k +: 2] = lvl(1'b1, n.slot == k, n.ph,
                                          n.third, n.mux == 2'h0);
        end
        for (int p = 0; p < lsd_pkg::N_SEG; p++) begin
            on = n.seg[n.slot][p];                               // [R5]
            if (p < lsd_pkg::N_BLINK && n.bmask[p % lsd_pkg::N_BLINK]
                && !n.bon)
                on = 1'b0;                                       // [R7]
            if (run)
                n.seg_lvl[2*p +: 2] = lvl(1'b0, on, n.ph, n.third,
                                          n.mux == 2'h0);        // [R3]
        end

        // ----------------------------------------
        // Read port
        // ----------------------------------------
        // Answer stands one cycle only, then reads as zero
        n.rdata = '0;
        if (bus.rd) begin
            if (seg_word(bus.addr)) begin
                if (bus.addr[0])
                    n.rdata = {24'h000000, s.seg[wc][39:32]};
                else
                    n.rdata = s.seg[wc][31:0];
            end else begin
                case (bus.addr)
                    lsd_pkg::A_CTRL:
                        n.rdata = ctrl_word(s);
                    lsd_pkg::A_DIV:      n.rdata = {16'h0000, s.div};
                    lsd_pkg::A_DISCH:    n.rdata = {24'h000000, s.dis};
                    lsd_pkg::A_CONTRAST: n.rdata = {26'h0000000, s.con};
                    lsd_pkg::A_BLINK:
                        n.rdata = {16'h0000, s.brate, s.bmask};
                    lsd_pkg::A_STATUS:
                        n.rdata = status_word(s);                // [R11]
                    lsd_pkg::A_INTEN:    n.rdata = {28'h0000000, s.ien};
                    default:             n.rdata = '0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            s       <= '0;
            s.seq   <= lsd_pkg::SQ_IDLE;
            s.div   <= lsd_pkg::DIV_RST;
            s.brate <= lsd_pkg::BRATE_RST;
            s.con   <= lsd_pkg::CON_RST;
            // Blink phase starts on so masked pins show at once
            s.bon   <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign rdata                = s.rdata;
    assign seg_level            = s.seg_lvl;
    assign common_drive_outputs = s.com_lvl;
    assign discharge            = s.disch;
    assign contrast             = s.con;                         // [R10]
    assign contrast_mode        = s.acm;                         // [R8]
    assign wake                 = s.wake;
    assign irq                  = s.irq;
endmodule : lsd_top

/* testbench/lsd_sva.sv */
// Port checker for the segment display controller
`timescale 1ns/1ns
module lsd_sva (
    input wire logic              mclk,
    input wire logic              rst,
    input wire lsd_pkg::lsd_bus_t bus,
    input wire logic              low_freq_timer_clock,
    input wire logic              vbat_low,
    input wire logic              deepest_sleep_mode,
    input wire logic [31:0]       rdata,
    input wire logic [79:0]       seg_level,
    input wire logic [7:0]        common_drive_outputs,
    input wire logic              discharge,
    input wire logic [5:0]        contrast,
    input wire logic [1:0]        contrast_mode,
    input wire logic              wake,
    input wire logic              irq
);
    logic [1:0] mux_q;
    logic       wken_q;
    logic       third_q;
    logic [2:0] age_q;
    logic       cw;
    logic [7:0] com_mask;
    logic [3:0] hi;
    assign cw = bus.wr && bus.addr == lsd_pkg::A_CTRL;
    assign com_mask = 8'hff >> {2'h3 - mux_q, 1'b0};
    // Selected common sits at the top level in phase zero only
    always_comb begin
        for (int k = 0; k < 4; k++)
            hi[k] = common_drive_outputs[2*k+:2] == (third_q ? 2'h3 : 2'h2);
    end
    // Age lets the sequencer settle after a mode change
    always_ff @(posedge mclk) begin
        if (rst) begin
            mux_q  <= 2'h0;
            wken_q <= 1'b0;
            third_q <= 1'b0;
            age_q  <= 3'h0;
        end else if (cw) begin
            mux_q  <= bus.wdata[lsd_pkg::C_MUX+:2];
            wken_q <= bus.wdata[lsd_pkg::C_WKEN];
            third_q <= bus.wdata[lsd_pkg::C_THIRD];
            age_q  <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_con;
        bus.wr && bus.addr == lsd_pkg::A_CONTRAST
            |=> ##1 contrast == $past(bus.wdata[5:0], 2);
    endproperty
    a_con: assert property (p_con)
        else $error("contrast output does not follow write");
    property p_acm;
        cw |=> ##1 contrast_mode == $past(bus.wdata[5:4], 2);
    endproperty
    a_acm: assert property (p_acm)
        else $error("contrast mode does not follow write");
    property p_disch;
        discharge |-> seg_level == 80'h0 && common_drive_outputs == 8'h0;
    endproperty
    a_disch: assert property (p_disch)
        else $error("pins not at level zero in discharge");
    property p_off;
        cw && !bus.wdata[lsd_pkg::C_EN]
            |-> ##[1:3] (seg_level == 80'h0 && common_drive_outputs == 8'h0);
    endproperty
    a_off: assert property (p_off)
        else $error("pins not idle after disable");
    property p_unused;
        age_q == 3'h7 |-> (common_drive_outputs & ~com_mask) == 8'h0;
    endproperty
    a_unused: assert property (p_unused)
        else $error("common above mux ratio not inactive");
    property p_one_sel;
        age_q == 3'h7 |-> $countones(hi) <= 1;
    endproperty
    a_one_sel: assert property (p_one_sel)
        else $error("more than one common selected");
    property p_wake;
        $rose(vbat_low) && wken_q |-> ##[2:4] wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake after battery trip");
    property p_wake_off;
        !wken_q && age_q == 3'h7 |-> !wake;
    endproperty
    a_wake_off: assert property (p_wake_off)
        else $error("wake while not enabled");
    property p_irq_off;
        (bus.wr && bus.addr == lsd_pkg::A_INTEN && bus.wdata[3:0] == 4'h0)
            ##1 !(bus.wr && bus.addr == lsd_pkg::A_INTEN) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt with all sources masked");
endmodule : lsd_sva
bind lsd_top lsd_sva u_sva (.mclk(mclk), .rst(rst), .bus(bus),
    .low_freq_timer_clock(low_freq_timer_clock), .vbat_low(vbat_low),
    .deepest_sleep_mode(deepest_sleep_mode), .rdata(rdata),
    .seg_level(seg_level), .common_drive_outputs(common_drive_outputs),
    .discharge(discharge), .contrast(contrast),
    .contrast_mode(contrast_mode), .wake(wake), .irq(irq));

/* testbench/lsd_panel.sv */
// Passive glass model: sticky lit flags for segment pins 0 to 31 on common zero
`timescale 1ns/1ns
module lsd_panel (
    input wire logic        mclk,
    input wire logic [79:0] seg_level,
    input wire logic [7:0]  common_drive_outputs,
    input wire logic [1:0]  thr,
    input wire logic        clr,
    output logic [31:0]     lit
);
    logic [1:0] s;
    logic [1:0] c;
    // Only full swing lights a pixel; partial swing stays dark
    always @(posedge mclk) begin
        c = common_drive_outputs[1:0];
        for (int p = 0; p < 32; p++) begin
            s = seg_level[2*p+:2];
            if (clr)
                lit[p] <= 1'b0;
            else if ((c > s ? c - s : s - c) >= thr)
                lit[p] <= 1'b1;
        end
    end
endmodule : lsd_panel

/* testbench/tb_lcd_segment_driver_control.sv */
// Self-checking bench for the segment display controller
`timescale 1ns/1ns
module tb_lcd_segment_driver_control;
    logic mclk, discharge, wake, irq;
    logic rst = 1'b1, lfclk = 1'b0, vbat_low = 1'b0, sleep = 1'b0;
    logic clr = 1'b0, rd_seen = 1'b0;
    lsd_pkg::lsd_bus_t bus = '0;
    logic [31:0] rdata, pat, v, lit;
    logic [79:0] seg_level;
    logic [7:0]  coms;
    logic [5:0]  contrast;
    logic [1:0]  cmode;
    logic [1:0]  thr = 2'h2;
    logic [63:0] e;
    logic [63:0] expq[$];
    int mismatches, comparisons;
    lsd_top dut (.mclk(mclk), .rst(rst), .bus(bus),
        .low_freq_timer_clock(lfclk), .vbat_low(vbat_low),
        .deepest_sleep_mode(sleep), .rdata(rdata), .seg_level(seg_level),
        .common_drive_outputs(coms), .discharge(discharge),
        .contrast(contrast), .contrast_mode(cmode), .wake(wake), .irq(irq));
    lsd_panel u_panel (.mclk(mclk), .seg_level(seg_level),
        .common_drive_outputs(coms), .thr(thr), .clr(clr), .lit(lit));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, x);
        expq.push_back({m, x});
        @(posedge mclk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge mclk);
        bus.rd <= 1'b0;
    endtask : rd
    // Timer edges last long enough to pass the two-stage synchroniser
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            lfclk <= 1'b1;
            repeat (5) @(posedge mclk);
            lfclk <= 1'b0;
            repeat (5) @(posedge mclk);
        end
    endtask : tick
    task automatic look();
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask : look
    always @(posedge mclk) begin
        if (rd_seen && expq.size() > 0) begin
            e = expq.pop_front();
            chk("rdata", rdata & e[63:32], e[31:0] & e[63:32]);
        end
        rd_seen <= bus.rd;
    end
    initial begin
        v = $urandom(47055);
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd(lsd_pkg::A_DIV, 32'hffff, 32'h1);
        rd(lsd_pkg::A_BLINK, 32'hffff, 32'h1000);
        rd(lsd_pkg::A_CONTRAST, 32'h3f, 32'h20);
        wr(lsd_pkg::A_STATUS, 32'hf);
        rd(lsd_pkg::A_STATUS, 32'hf, 32'h0);
        rd(4'hf, 32'hffffffff, 32'h0);
        v = $urandom & 32'h3f;
        wr(lsd_pkg::A_CONTRAST, v);
        look();
        chk("contrast", {26'h0, contrast}, v);
        for (int m = 0; m < 4; m++) begin
            wr(lsd_pkg::A_CTRL, m << lsd_pkg::C_ACM);
            look();
            chk("mode", {30'h0, cmode}, m);
        end
        wr(lsd_pkg::A_DIV, 32'h0);
        wr(lsd_pkg::A_INTEN, 32'h1);
        for (int m = 0; m < 4; m++) begin
            sleep <= (m == 3);
            wr(lsd_pkg::A_CTRL, 32'h0);
            wr(lsd_pkg::A_CTRL, 32'h1 | (m << lsd_pkg::C_MUX));
            wr(lsd_pkg::A_CLEAR, 32'hf);
            tick(2 * m + 1);
            rd(lsd_pkg::A_STATUS, 32'h1, 32'h0);
            tick(1);
            rd(lsd_pkg::A_STATUS, 32'h101, {23'h0, m == 3, 8'h1});
        end
        look();
        chk("irq", {31'h0, irq}, 32'h1);
        wr(lsd_pkg::A_INTEN, 32'h0);
        look();
        chk("irq", {31'h0, irq}, 32'h0);
        wr(lsd_pkg::A_INTEN, 32'h1);
        wr(lsd_pkg::A_CLEAR, 32'h1);
        look();
        chk("irq", {31'h0, irq}, 32'h0);
        for (int b = 0; b < 2; b++) begin
            pat = $urandom;
            wr(lsd_pkg::A_CTRL, 32'h0);
            wr(4'h8, pat);
            wr(4'ha, ~pat);
            wr(lsd_pkg::A_CTRL, 32'h3 | (b << lsd_pkg::C_THIRD));
            thr <= b ? 2'h3 : 2'h2;
            clr <= 1'b1;
            repeat (3) @(posedge mclk);
            clr <= 1'b0;
            tick(4);
            look();
            chk("lit", lit, pat);
        end
        wr(lsd_pkg::A_DISCH, 32'h2);
        for (int k = 0; k < 3; k++) begin
            tick(1);
            look();
            chk("discharge", {31'h0, discharge}, k < 2);
        end
        rd(lsd_pkg::A_STATUS, 32'h8, 32'h8);
        wr(lsd_pkg::A_DISCH, 32'h0);
        wr(lsd_pkg::A_BLINK, 32'hff);
        wr(lsd_pkg::A_CLEAR, 32'hf);
        tick(4);
        rd(lsd_pkg::A_STATUS, 32'h4, 32'h4);
        wr(lsd_pkg::A_CTRL, 32'h43);
        vbat_low <= 1'b1;
        look();
        chk("wake", {31'h0, wake}, 32'h1);
        rd(lsd_pkg::A_STATUS, 32'h2, 32'h2);
        wr(lsd_pkg::A_CTRL, 32'h3);
        look();
        chk("wake", {31'h0, wake}, 32'h0);
        report_and_stop();
    end
endmodule : tb_lcd_segment_driver_control
